// file: verilog/ov_fault_handler.sv
// Over-voltage fault supervision, response sequencer and registers
`timescale 1ns/1ps
module ov_fault_handler (
  input wire logic clock,
  input wire logic rst_n,
  input wire ov_fault_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] iout_raw,
  output logic [15:0] iout_report,
  input wire logic [15:0] time_unit_cycles,
  input wire ov_fault_pkg::clear_ev_s clear_ev,
  output logic output_enable,
  output logic ov_fault_flag,
  output logic ov_warn_flag
);
  import ov_fault_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ov_regs_s s_r;
  ov_regs_s s_nxt;

  logic [1:0] resp;
  logic [2:0] retries;
  logic [2:0] delay_n;
  logic ov_now;
  logic warn_now;
  logic clear_any;
  logic timer_done;
  logic [15:0] unit_len;

  assign resp = s_r.action[ACT_RESP_MSB:ACT_RESP_LSB];
  assign retries = s_r.action[ACT_RETRY_MSB:ACT_RETRY_LSB];
  assign delay_n = s_r.action[ACT_DELAY_MSB:ACT_DELAY_LSB];
  assign ov_now = vout_meas > s_r.fault_thr;
  assign warn_now = vout_meas > s_r.warn_thr;
  // Output commanded off also counts as a clear
  assign clear_any = clear_ev.status_clear | clear_ev.clear_faults |
                     ~clear_ev.output_on_cmd;
  // A zero unit would wrap the count to 16'hffff, a 65536-cycle unit
  assign unit_len = (time_unit_cycles == 16'h0000) ? 16'h0001 :
                    time_unit_cycles;
  assign timer_done = (s_r.units_left == 8'h01) &&
                      (s_r.sub_left == 16'h0000);

  always_comb begin
    s_nxt = s_r;
    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (reg_req.wr) begin
      if (reg_req.cmd == CMD_CURRENT_READING_OFFSET) begin
        s_nxt.iout_offset = reg_req.wdata;
      end else if (reg_req.cmd == CMD_OVERVOLTAGE_FAULT_THRESHOLD) begin
        s_nxt.fault_thr = reg_req.wdata;
      end else if (reg_req.cmd == CMD_OVERVOLTAGE_FAULT_ACTION) begin
        s_nxt.action = reg_req.wdata[7:0];
      end else if (reg_req.cmd == CMD_OVERVOLTAGE_WARNING_THRESHOLD) begin
        s_nxt.warn_thr = reg_req.wdata;
      end
    end
    // Unmapped codes read as zero
    if (reg_req.cmd == CMD_CURRENT_READING_OFFSET) begin
      s_nxt.rdata = s_r.iout_offset;
    end else if (reg_req.cmd == CMD_OVERVOLTAGE_FAULT_THRESHOLD) begin
      s_nxt.rdata = s_r.fault_thr;
    end else if (reg_req.cmd == CMD_OVERVOLTAGE_FAULT_ACTION) begin
      s_nxt.rdata = {8'h00, s_r.action};
    end else if (reg_req.cmd == CMD_OVERVOLTAGE_WARNING_THRESHOLD) begin
      s_nxt.rdata = s_r.warn_thr;
    end else begin
      s_nxt.rdata = 16'h0000;
    end

    s_nxt.iout_report = iout_raw + s_r.iout_offset;

    // --------------------------------------------------------------
    // Flags: a new event wins over a clear in the same cycle
    // --------------------------------------------------------------
    if (clear_ev.status_clear || clear_ev.clear_faults) begin
      s_nxt.warn_flag = 1'b0;
    end
    if (warn_now) begin
      s_nxt.warn_flag = 1'b1;
    end
    if (clear_any) begin
      s_nxt.fault_flag = 1'b0;
    end
    if (ov_now) begin
      s_nxt.fault_flag = 1'b1;
    end

    // --------------------------------------------------------------
    // Interval timer: 2**n units of unit_len cycles
    // --------------------------------------------------------------
    if (s_r.sub_left != 16'h0000) begin
      s_nxt.sub_left = s_r.sub_left - 16'h0001;
    end else if (s_r.units_left > 8'h01) begin
      s_nxt.units_left = s_r.units_left - 8'h01;
      s_nxt.sub_left = unit_len - 16'h0001;
    end

    // --------------------------------------------------------------
    // Response sequencer
    // --------------------------------------------------------------
    case (s_r.state)
      ST_RUN: begin
        if (ov_now) begin
          if (resp == RESP_RIDE) begin
            s_nxt.state = ST_RIDE;
            s_nxt.units_left = 8'h01 << delay_n;
            s_nxt.sub_left = unit_len - 16'h0001;
          end else if (resp == RESP_DISABLE_RETRY) begin
            s_nxt.state = ST_SPACE;
            s_nxt.units_left = 8'h01 << delay_n;
            s_nxt.sub_left = unit_len - 16'h0001;
            if (retries == RETRY_NONE) begin
              s_nxt.state = ST_LATCH;
            end else if (retries != RETRY_FOREVER &&
                         s_r.attempts >= retries) begin
              s_nxt.state = ST_LATCH;
            end
          end else if (resp == RESP_OFF_WHILE) begin
            s_nxt.state = ST_HOLD;
          end
          // Ignore leaves the converter running
        end
      end
      ST_RIDE: begin
        if (timer_done) begin
          if (!ov_now) begin
            s_nxt.state = ST_RUN;
          end else if (retries == RETRY_NONE) begin
            s_nxt.state = ST_LATCH;
          end else if (retries != RETRY_FOREVER &&
                       s_r.attempts >= retries) begin
            s_nxt.state = ST_LATCH;
          end else begin
            s_nxt.state = ST_SPACE;
            s_nxt.units_left = 8'h01 << delay_n;
            s_nxt.sub_left = unit_len - 16'h0001;
          end
        end
      end
      ST_SPACE: begin
        if (timer_done) begin
          s_nxt.state = ST_RUN;
          if (retries != RETRY_FOREVER) begin
            s_nxt.attempts = s_r.attempts + 3'h1;
          end
        end
      end
      ST_HOLD: begin
        if (!ov_now) begin
          s_nxt.state = ST_RUN;
        end
      end
      ST_LATCH: begin
        s_nxt.state = ST_LATCH;
      end
      default: begin
        s_nxt.state = ST_RUN;
      end
    endcase

    // Clearing ends any sequence and restores the attempt budget
    if (clear_any) begin
      s_nxt.state = ST_RUN;
      s_nxt.attempts = 3'h0;
      if (!clear_ev.output_on_cmd) begin
        s_nxt.state = ST_RUN;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r <= '{state: ST_RUN,
               iout_offset: RST_CURRENT_READING_OFFSET,
               fault_thr: RST_FAULT_THRESHOLD,
               action: RST_FAULT_ACTION,
               warn_thr: RST_WARNING_THRESHOLD,
               rdata: 16'h0000,
               iout_report: 16'h0000,
               fault_flag: 1'b0,
               warn_flag: 1'b0,
               attempts: 3'h0,
               units_left: 8'h01,
               sub_left: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign iout_report = s_r.iout_report;
  assign ov_fault_flag = s_r.fault_flag;
  assign ov_warn_flag = s_r.warn_flag;
  // Output follows the commanded state and the sequencer
  assign output_enable = clear_ev.output_on_cmd &&
                         (s_r.state == ST_RUN || s_r.state == ST_RIDE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_offset_sum: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    ##1 iout_report == $past(iout_raw) + $past(s_r.iout_offset))
    else $error("current report lacks offset");
  a_ignore_runs: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_RUN && resp == RESP_IGNORE && !clear_any)
      |=> s_r.state == ST_RUN)
    else $error("ignore mode left run");
  a_ride_on: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_RUN && ov_now && resp == RESP_RIDE && !clear_any)
      |=> s_r.state == ST_RIDE && output_enable == clear_ev.output_on_cmd)
    else $error("ride-through did not keep output on");
  a_disable_now: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_RUN && ov_now && resp == RESP_DISABLE_RETRY &&
     !clear_any) |=> !output_enable)
    else $error("output not disabled on fault");
  a_hold_release: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_HOLD && !ov_now && !clear_any)
      |=> s_r.state == ST_RUN)
    else $error("hold did not release");
  a_clear_flag: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (clear_ev.clear_faults && !ov_now)
      |=> !ov_fault_flag && s_r.state == ST_RUN)
    else $error("clear did not drop fault");
  a_no_retry: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_LATCH && !clear_any) |=> s_r.state == ST_LATCH)
    else $error("latched off left without clear");
  // Judged at entry to spacing, against the setting that sent it there
  a_budget: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    ($rose(s_r.state == ST_SPACE) && $past(retries) != RETRY_FOREVER)
      |-> s_r.attempts < $past(retries))
    else $error("restart attempts exceed setting");
  a_forever: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_SPACE && timer_done && retries == RETRY_FOREVER &&
     !clear_any) |=> s_r.state == ST_RUN && $stable(s_r.attempts))
    else $error("continuous retry stopped");
  a_fault_set: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    ov_now |=> ov_fault_flag)
    else $error("fault flag missed");
  a_warn_set: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    warn_now |=> ov_warn_flag)
    else $error("warning flag missed");
  a_unit_load: assert property (
    @(posedge clock) disable iff (!rst_sync_r)
    (s_r.state == ST_RUN && ov_now && resp == RESP_RIDE && !clear_any)
      |=> s_r.units_left == (8'h01 << $past(delay_n)))
    else $error("delay units wrong");

endmodule // ov_fault_handler

// file: verilog/ov_fault_pkg.sv
// Constants, types and register map for output over-voltage supervision
package ov_fault_pkg;

  // ----------------------------------------------------------------
  // Register command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CURRENT_READING_OFFSET = 8'h39;
  localparam logic [7:0] CMD_OVERVOLTAGE_FAULT_THRESHOLD = 8'h40;
  localparam logic [7:0] CMD_OVERVOLTAGE_FAULT_ACTION = 8'h41;
  localparam logic [7:0] CMD_OVERVOLTAGE_WARNING_THRESHOLD = 8'h42;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CURRENT_READING_OFFSET = 16'h0000;
  localparam logic [15:0] RST_FAULT_THRESHOLD = 16'hffff;
  localparam logic [7:0] RST_FAULT_ACTION = 8'h80;
  localparam logic [15:0] RST_WARNING_THRESHOLD = 16'hffff;

  // ----------------------------------------------------------------
  // Field layout of the action register
  // ----------------------------------------------------------------
  localparam int ACT_RESP_MSB = 7;
  localparam int ACT_RESP_LSB = 6;
  localparam int ACT_RETRY_MSB = 5;
  localparam int ACT_RETRY_LSB = 3;
  localparam int ACT_DELAY_MSB = 2;
  localparam int ACT_DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RIDE = 2'h1;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] RESP_OFF_WHILE = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_RIDE,
    ST_SPACE,
    ST_HOLD,
    ST_LATCH
  } ov_state_e;

  // Register-port request
  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } reg_req_s;

  // Clear events from the surrounding controller
  typedef struct packed {
    logic status_clear;
    logic clear_faults;
    logic output_on_cmd;
  } clear_ev_s;

  typedef struct packed {
    ov_state_e state;
    logic [15:0] iout_offset;
    logic [15:0] fault_thr;
    logic [7:0] action;
    logic [15:0] warn_thr;
    logic [15:0] rdata;
    logic [15:0] iout_report;
    logic fault_flag;
    logic warn_flag;
    logic [2:0] attempts;
    logic [7:0] units_left;
    logic [15:0] sub_left;
  } ov_regs_s;

endpackage

// file: test/host_model.sv
// Host model that drives register writes, selects and clear events
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  output ov_fault_pkg::reg_req_s reg_req,
  output ov_fault_pkg::clear_ev_s clear_ev
);
  import ov_fault_pkg::*;
  initial begin
    reg_req = '0;
    clear_ev = 3'h1;
  end
  // Cmd is held after a write so the read path echoes it
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock);
    reg_req <= '{1'b1, c, d};
    @(posedge clock);
    reg_req.wr <= 1'b0;
    // Released data lines show the inverse, not a stale copy
    reg_req.wdata <= ~d;
  endtask
  task automatic sel(input logic [7:0] c);
    @(posedge clock);
    reg_req.cmd <= c;
    @(posedge clock);
  endtask
  // Kind 0 is a status-bit clear, kind 1 a clear-faults command
  task automatic clr(input int k);
    @(posedge clock);
    if (k == 0) clear_ev.status_clear <= 1'b1;
    else clear_ev.clear_faults <= 1'b1;
    @(posedge clock);
    clear_ev <= 3'h1;
  endtask
  task automatic on(input logic b);
    @(posedge clock);
    clear_ev.output_on_cmd <= b;
  endtask
endmodule // host_model

// file: test/ov_fault_handler_tb_top.sv
// Self-checking bench for the over-voltage fault handler
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module ov_fault_handler_tb_top;
  import ov_fault_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic [15:0] val;
  } note_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] vout_meas = 16'h0;
  logic [15:0] iout_raw = 16'h0;
  logic [15:0] time_unit_cycles = 16'h2;
  logic [15:0] seed = 16'h001a;
  logic [15:0] reg_rdata, iout_report, v, off;
  logic output_enable, ov_fault_flag, ov_warn_flag;
  reg_req_s reg_req;
  clear_ev_s clear_ev;
  note_s notes[$];
  note_s n;
  int bad_count = 0, check_count = 0, cycles = 0, restarts = 0;
  string nm[6] = '{"reg_rdata", "iout_report", "output_enable",
                   "ov_fault_flag", "ov_warn_flag", "restarts"};
  logic [7:0] cmds[4] = '{CMD_CURRENT_READING_OFFSET,
    CMD_OVERVOLTAGE_FAULT_THRESHOLD, CMD_OVERVOLTAGE_FAULT_ACTION,
    CMD_OVERVOLTAGE_WARNING_THRESHOLD};
  logic [15:0] rstv[4] = '{RST_CURRENT_READING_OFFSET,
    RST_FAULT_THRESHOLD, {8'h00, RST_FAULT_ACTION}, RST_WARNING_THRESHOLD};
  always #2.5 clock = ~clock;
  ov_fault_handler dut (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .vout_meas(vout_meas), .iout_raw(iout_raw),
    .iout_report(iout_report), .time_unit_cycles(time_unit_cycles),
    .clear_ev(clear_ev), .output_enable(output_enable),
    .ov_fault_flag(ov_fault_flag), .ov_warn_flag(ov_warn_flag));
  host_model h (.clock(clock), .reg_req(reg_req), .clear_ev(clear_ev));
  // ----------------------------------------------------------------
  // Helpers and result watcher
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [15:0] got(input logic [2:0] s);
    case (s)
      3'h0: return reg_rdata;
      3'h1: return iout_report;
      3'h2: return {15'h0, output_enable};
      3'h3: return {15'h0, ov_fault_flag};
      3'h4: return {15'h0, ov_warn_flag};
      default: return (restarts > 6) ? 16'h1 : 16'h0;
    endcase
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic ck(input int s, input logic [15:0] e);
    notes.push_back('{s[2:0], e});
  endtask
  task automatic setv(input logic [15:0] x);
    @(posedge clock);
    vout_meas <= x;
  endtask
  task automatic act(input logic [15:0] a);
    setv(16'h0);
    h.wr(CMD_OVERVOLTAGE_FAULT_ACTION, a);
    h.clr(1);
  endtask
  task automatic test_done();
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Falling edge keeps the compare clear of launch-edge updates
  always @(negedge clock) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      `CHK(nm[n.sel], n.val, got(n.sel))
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    cyc(3);
    // Reset values, then an unmapped code that must read zero
    for (int i = 0; i < 5; i++) begin
      h.sel(i < 4 ? cmds[i] : 8'h43);
      ck(0, i < 4 ? rstv[i] : 16'h0);
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      h.wr(cmds[i], v);
      cyc(1);
      ck(0, i == 2 ? {8'h00, v[7:0]} : v);
    end
    for (int i = 0; i < 4; i++) begin
      off = rnd();
      v = rnd();
      h.wr(CMD_CURRENT_READING_OFFSET, off);
      iout_raw <= v;
      cyc(2);
      ck(1, v + off);
    end
    h.wr(CMD_OVERVOLTAGE_FAULT_THRESHOLD, 16'h3000);
    h.wr(CMD_OVERVOLTAGE_WARNING_THRESHOLD, 16'h2000);
    act(16'h0000);
    setv(16'h2000);
    cyc(2);
    ck(4, 16'h0);
    setv(16'h2001);
    cyc(1);
    ck(4, 16'h1);
    setv(16'h3000);
    cyc(2);
    ck(3, 16'h0);
    setv(16'h3001);
    cyc(1);
    ck(3, 16'h1);
    cyc(10);
    ck(2, 16'h1);
    // Random voltages; the clear lands while the new level is applied
    repeat (8) begin
      setv(rnd());
      h.clr(0);
      ck(3, {15'h0, vout_meas > 16'h3000});
      ck(4, {15'h0, vout_meas > 16'h2000});
    end
    // Latched shutdown left by each kind of clear event
    act(16'h0080);
    for (int k = 0; k < 3; k++) begin
      setv(16'h3001);
      cyc(1);
      ck(2, 16'h0);
      cyc(20);
      ck(2, 16'h0);
      setv(16'h0);
      if (k < 2) h.clr(k);
      else begin
        h.on(1'b0);
        h.on(1'b1);
      end
      cyc(1);
      ck(2, 16'h1);
      ck(3, 16'h0);
    end
    // One retry, spacing of two units at two unit lengths
    act(16'h0089);
    for (int u = 1; u < 4; u += 2) begin
      time_unit_cycles <= u[15:0];
      h.clr(1);
      setv(16'h3001);
      setv(16'h0);
      ck(2, 16'h0);
      cyc(2 * u - 1);
      ck(2, 16'h0);
      cyc(1);
      ck(2, 16'h1);
      setv(16'h3001);
      cyc(30);
      ck(2, 16'h0);
      setv(16'h0);
    end
    act(16'h00b8);
    time_unit_cycles <= 16'h1;
    setv(16'h3001);
    repeat (60) begin
      @(posedge clock);
      #1;
      if (output_enable === 1'b1) restarts++;
    end
    ck(5, 16'h1);
    h.on(1'b0);
    ck(2, 16'h0);
    setv(16'h0);
    h.on(1'b1);
    act(16'h004a);
    time_unit_cycles <= 16'h2;
    setv(16'h3001);
    cyc(6);
    ck(2, 16'h1);
    ck(3, 16'h1);
    cyc(8);
    ck(2, 16'h0);
    act(16'h00c0);
    setv(16'h3001);
    cyc(6);
    ck(2, 16'h0);
    setv(16'h0);
    cyc(2);
    ck(2, 16'h1);
    cyc(2);
    test_done();
  end
endmodule // ov_fault_handler_tb_top
